// ### inc/cxs_defs.svh
// Purpose: Offsets, field positions, reset values and codes of the exception sequencer
// Assumes: Included by its bare name by the package user files
// Notes: Definitions only
`ifndef CXS_DEFS_SVH
`define CXS_DEFS_SVH

// Register offsets on the plain register port
`define CXS_REG_VBR 8'h00
`define CXS_REG_SSP 8'h04
`define CXS_REG_STATUS 8'h08
`define CXS_REG_INFO 8'h0C

// Status word fields
`define CXS_SR_T 15
`define CXS_SR_S 13
`define CXS_SR_M 12
`define CXS_SR_IMSK_HI 10
`define CXS_SR_IMSK_LO 8
`define CXS_SR_RESET 16'h2700

// Vector base register
`define CXS_VBR_RESET 32'h0000_0000
`define CXS_VBR_MASK 32'hFFF0_0000

// Vector numbers
`define CXS_VEC_INIT_SSP 8'h00
`define CXS_VEC_INIT_PC 8'h01
`define CXS_VEC_ACCESS 8'h02
`define CXS_VEC_ADDRESS 8'h03
`define CXS_VEC_ILLEGAL 8'h04
`define CXS_VEC_DIVZ 8'h05
`define CXS_VEC_PRIV 8'h08
`define CXS_VEC_TRACE 8'h09
`define CXS_VEC_LINEA 8'h0A
`define CXS_VEC_LINEF 8'h0B
`define CXS_VEC_DEBUG 8'h0C
`define CXS_VEC_FORMAT 8'h0E
`define CXS_VEC_TRAP0 8'h20

// Frame format and fault status codes
`define CXS_FMT_HI 2'b01
`define CXS_FS_NONE 4'h0
`define CXS_FS_IFETCH 4'h4
`define CXS_FS_OPWR 4'h8
`define CXS_FS_WPROT 4'h9
`define CXS_FS_OPRD 4'hC
`define CXS_FRAME_BYTES 32'h0000_0008
`define CXS_LONG_BYTES 32'h0000_0004

// Interrupt acknowledge window, level sits in address bits 4:2
`define CXS_INTERRUPT_ACK_CYCLE_BASE 32'hFFFF_FFE0

`endif

// ### inc/cxs_pkg.sv
// Purpose: Types shared by the exception sequencer
// Assumes: Nothing beyond the tool's SystemVerilog support
// Notes: Constants live in cxs_defs.svh
package cxs_pkg;

  typedef enum logic [7:0] {
    CXS_ST_IDLE = 8'h01,
    CXS_ST_RST_SSP = 8'h02,
    CXS_ST_RST_PC = 8'h04,
    CXS_ST_INTERRUPT_ACK_CYCLE = 8'h08,
    CXS_ST_PUSH_PC = 8'h10,
    CXS_ST_PUSH_FV = 8'h20,
    CXS_ST_VEC_RD = 8'h40,
    CXS_ST_FETCH = 8'h80
  } cxs_state_t;

  typedef enum logic [3:0] {
    CXS_K_ADDRESS = 4'h0,
    CXS_K_ILLEGAL = 4'h1,
    CXS_K_DIVZ = 4'h2,
    CXS_K_PRIV = 4'h3,
    CXS_K_TRACE = 4'h4,
    CXS_K_LINEA = 4'h5,
    CXS_K_LINEF = 4'h6,
    CXS_K_DEBUG = 4'h7,
    CXS_K_FORMAT = 4'h8,
    CXS_K_TRAP = 4'h9
  } cxs_kind_t;

endpackage

// ### hw/cxs_exception_sequencer.sv
// Purpose: Exception entry sequencer: status update, frame push, vector fetch, handler fetch
// Assumes: Core stalls while o_busy is high; memory answers with i_bus_ack
// Notes: No rollback of partial state; the core keeps or discards it as told
// Contract
// RULE_01: Save status copy, set supervisor, clear trace before building the frame.
// RULE_02: Interrupts also clear master flag and load mask with serviced level.
// RULE_03: Faults derive vector from type; interrupts run acknowledge cycle with level.
// RULE_04: Frame goes at a four-byte aligned address below supervisor stack pointer.
// RULE_05: Stacked counter is faulting or next instruction address by type.
// RULE_06: Handler address read at vector base plus four times vector number.
// RULE_07: Table holds 256 four-byte vectors, base on a one-megabyte boundary.
// RULE_08: Vectors 64 up serve peripheral interrupts and stack next address.
// RULE_09: Vector 0 gives initial stack pointer, vector 1 initial counter.
// RULE_10: Fixed vectors per fault type with fault or next stacked counter.
// RULE_11: Traps use vectors 32 to 47, next address; reserved vectors unused.
// RULE_12: No interrupt sampling during the first handler instruction.
// RULE_13: Frame is format/vector word over status, then counter longword.
// RULE_14: Format field 0100 to 0111 from stack pointer low bits.
// RULE_15: Fault status filled only for access and address errors, else zero.
// RULE_16: Fault codes: fetch 0100, write 1000, protected 1001, read 1100.
// RULE_17: Vector field holds computed number or controller supplied number.
// RULE_18: Fetch faults wait until used; change of flow discards them.
// RULE_19: Faulted opword aborts instruction before any state change.
// RULE_20: Read error aborts at once; earlier register updates stay.
// RULE_21: Write errors reported imprecisely after writer completed.
// RULE_22: Barrier instruction stalls for pending writes and reports their error.
// RULE_23: Processing ends once the first handler opcode fetch issues.
// RULE_24: Debug interrupt uses vector 12, no acknowledge, mask and master kept.
// RULE_25: Counter at higher address, status longword lower, stack pointer there.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "cxs_defs.svh"

module cxs_exception_sequencer
  import cxs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire logic i_exc_req,
  input wire cxs_kind_t i_exc_kind,
  input wire logic [3:0] i_trap_num,
  input wire logic [3:0] i_addr_err_fs,
  input wire logic [31:0] i_fault_pc,
  input wire logic [31:0] i_next_pc,
  input wire logic i_fetch_fault,
  input wire logic i_flow_change,
  input wire logic i_fault_word_used,
  input wire logic i_read_err,
  input wire logic i_write_err,
  input wire logic i_write_prot,
  input wire logic i_writes_pending,
  input wire logic i_nop_active,
  input wire logic i_instr_boundary,
  input wire logic i_instr_done,
  input wire logic [2:0] i_irq_level,
  output logic o_exc_taken,
  output logic o_abort,
  output logic o_nop_stall,
  output logic o_busy,
  output logic o_bus_req,
  output logic o_bus_wr,
  output logic o_bus_interrupt_ack_cycle,
  output logic [31:0] o_bus_addr,
  output logic [31:0] o_bus_wdata,
  input wire logic i_bus_ack,
  input wire logic [31:0] i_bus_rdata,
  output logic o_fetch_req,
  output logic [31:0] o_fetch_addr,
  output logic [15:0] o_status_word,
  output logic [31:0] o_ssp
);

  function automatic logic [7:0] kind_vec(input cxs_kind_t kind, input logic [3:0] trap);
    case (kind)
      CXS_K_ADDRESS: kind_vec = `CXS_VEC_ADDRESS;
      CXS_K_ILLEGAL: kind_vec = `CXS_VEC_ILLEGAL;
      CXS_K_DIVZ: kind_vec = `CXS_VEC_DIVZ;
      CXS_K_PRIV: kind_vec = `CXS_VEC_PRIV;
      CXS_K_TRACE: kind_vec = `CXS_VEC_TRACE;
      CXS_K_LINEA: kind_vec = `CXS_VEC_LINEA;
      CXS_K_LINEF: kind_vec = `CXS_VEC_LINEF;
      CXS_K_DEBUG: kind_vec = `CXS_VEC_DEBUG; // RULE_24
      CXS_K_FORMAT: kind_vec = `CXS_VEC_FORMAT;
      CXS_K_TRAP: kind_vec = `CXS_VEC_TRAP0 | {4'h0, trap}; // RULE_11
      default: kind_vec = `CXS_VEC_ILLEGAL;
    endcase
  endfunction

  // Types that resume after the causing instruction
  function automatic logic kind_next(input cxs_kind_t kind);
    case (kind)
      CXS_K_TRACE: kind_next = 1'b1;
      CXS_K_DEBUG: kind_next = 1'b1;
      CXS_K_TRAP: kind_next = 1'b1;
      default: kind_next = 1'b0;
    endcase
  endfunction

  cxs_state_t state_r, state_nxt;
  logic [15:0] status_r, status_nxt;
  logic [15:0] saved_sr_r, saved_sr_nxt;
  logic [31:0] ssp_r, ssp_nxt;
  logic [31:0] vbr_r, vbr_nxt;
  logic [7:0] vector_r, vector_nxt;
  logic [3:0] fs_r, fs_nxt;
  logic [1:0] fmt_r, fmt_nxt;
  logic [31:0] pc_stack_r, pc_stack_nxt;
  logic [31:0] frame_sp_r, frame_sp_nxt;
  logic [2:0] irq_lvl_r, irq_lvl_nxt;
  logic [31:0] bus_addr_r, bus_addr_nxt;
  logic [31:0] bus_wdata_r, bus_wdata_nxt;
  logic [31:0] handler_pc_r, handler_pc_nxt;
  logic inhibit_r, inhibit_nxt;
  logic fetch_pend_r, fetch_pend_nxt;
  logic wr_err_pend_r, wr_err_pend_nxt;
  logic wr_err_prot_r, wr_err_prot_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic idle;
  logic ev_ifetch, ev_rd, ev_exc, ev_nop, ev_wr, ev_irq, start;
  logic [7:0] ent_vec;
  logic [3:0] ent_fs;
  logic ent_next;
  logic ent_keep_mask;
  logic [31:0] sp_al;
  logic [31:0] frame_word;

  assign idle = (state_r == CXS_ST_IDLE);
  // Fetch faults only count when the faulted word is actually executed
  assign ev_ifetch = idle & fetch_pend_r & i_fault_word_used; // RULE_18
  assign ev_rd = idle & i_read_err; // RULE_20
  assign ev_exc = idle & i_exc_req;
  assign ev_nop = idle & wr_err_pend_r & i_nop_active & ~i_writes_pending; // RULE_22
  assign ev_wr = idle & wr_err_pend_r & i_instr_boundary; // RULE_21
  assign ev_irq = idle & i_instr_boundary & ~inhibit_r &
    (i_irq_level > status_r[`CXS_SR_IMSK_HI:`CXS_SR_IMSK_LO]); // RULE_12
  assign start = ev_ifetch | ev_rd | ev_exc | ev_nop | ev_wr | ev_irq;
  assign sp_al = {ssp_r[31:2], 2'b00}; // RULE_04
  // Format/vector word above the saved status word
  assign frame_word = {`CXS_FMT_HI, fmt_r, fs_r, vector_r, saved_sr_r}; // RULE_13

  // Entry decode, in priority order
  always_comb begin
    ent_vec = `CXS_VEC_ACCESS; // RULE_10
    ent_fs = `CXS_FS_NONE; // RULE_15
    ent_next = 1'b0;
    ent_keep_mask = 1'b1;
    if (ev_ifetch) begin
      ent_fs = `CXS_FS_IFETCH; // RULE_16
    end else if (ev_rd) begin
      ent_fs = `CXS_FS_OPRD; // RULE_16
    end else if (ev_exc) begin
      ent_vec = kind_vec(i_exc_kind, i_trap_num); // RULE_03
      ent_next = kind_next(i_exc_kind); // RULE_05
      if (i_exc_kind == CXS_K_ADDRESS) begin
        ent_fs = i_addr_err_fs;
      end
    end else if (ev_nop || ev_wr) begin
      ent_fs = wr_err_prot_r ? `CXS_FS_WPROT : `CXS_FS_OPWR; // RULE_16
      ent_next = ev_wr; // RULE_21
    end else if (ev_irq) begin
      ent_next = 1'b1; // RULE_08
      ent_keep_mask = 1'b0;
    end
  end

  // Sequencer next values
  always_comb begin
    state_nxt = state_r;
    status_nxt = status_r;
    saved_sr_nxt = saved_sr_r;
    ssp_nxt = ssp_r;
    vbr_nxt = vbr_r;
    vector_nxt = vector_r;
    fs_nxt = fs_r;
    fmt_nxt = fmt_r;
    pc_stack_nxt = pc_stack_r;
    frame_sp_nxt = frame_sp_r;
    irq_lvl_nxt = irq_lvl_r;
    bus_addr_nxt = bus_addr_r;
    bus_wdata_nxt = bus_wdata_r;
    handler_pc_nxt = handler_pc_r;
    inhibit_nxt = inhibit_r;
    // A new fault wins over a discard in the same cycle
    fetch_pend_nxt = (fetch_pend_r & ~i_flow_change & ~ev_ifetch) | i_fetch_fault; // RULE_18
    wr_err_pend_nxt = (wr_err_pend_r & ~(ev_nop | ev_wr)) | i_write_err;
    wr_err_prot_nxt = i_write_err ? (wr_err_prot_r & wr_err_pend_nxt) | i_write_prot :
      (wr_err_prot_r & wr_err_pend_nxt);
    if (i_instr_done) begin
      inhibit_nxt = 1'b0; // RULE_12
    end
    if (i_reg_wr && (i_reg_addr == `CXS_REG_VBR)) begin
      vbr_nxt = i_reg_wdata & `CXS_VBR_MASK; // RULE_07
    end
    if (i_reg_wr && idle && !start && (i_reg_addr == `CXS_REG_SSP)) begin
      ssp_nxt = i_reg_wdata;
    end
    if (i_reg_wr && idle && !start && (i_reg_addr == `CXS_REG_STATUS)) begin
      status_nxt = i_reg_wdata[15:0];
    end
    case (state_r)
      CXS_ST_IDLE: begin
        if (start) begin
          saved_sr_nxt = status_r; // RULE_01
          status_nxt[`CXS_SR_S] = 1'b1; // RULE_01
          status_nxt[`CXS_SR_T] = 1'b0; // RULE_01
          if (!ent_keep_mask) begin
            status_nxt[`CXS_SR_M] = 1'b0; // RULE_02
            status_nxt[`CXS_SR_IMSK_HI:`CXS_SR_IMSK_LO] = i_irq_level; // RULE_02
          end
          fs_nxt = ent_fs;
          fmt_nxt = ssp_r[1:0]; // RULE_14
          frame_sp_nxt = sp_al - `CXS_FRAME_BYTES; // RULE_14
          pc_stack_nxt = ent_next ? i_next_pc : i_fault_pc; // RULE_05
          irq_lvl_nxt = i_irq_level;
          vector_nxt = ent_vec; // RULE_17
          if (ev_irq && !(ev_ifetch | ev_rd | ev_exc | ev_nop | ev_wr)) begin
            state_nxt = CXS_ST_INTERRUPT_ACK_CYCLE;
            bus_addr_nxt = `CXS_INTERRUPT_ACK_CYCLE_BASE | {27'h000_0000, i_irq_level, 2'b00}; // RULE_03
          end else begin
            state_nxt = CXS_ST_PUSH_PC;
            bus_addr_nxt = sp_al - `CXS_LONG_BYTES; // RULE_25
            bus_wdata_nxt = ent_next ? i_next_pc : i_fault_pc;
          end
        end
      end
      CXS_ST_RST_SSP: begin
        if (i_bus_ack) begin
          ssp_nxt = i_bus_rdata; // RULE_09
          bus_addr_nxt = vbr_r + {22'h00_0000, `CXS_VEC_INIT_PC, 2'b00}; // RULE_09
          state_nxt = CXS_ST_RST_PC;
        end
      end
      CXS_ST_RST_PC: begin
        if (i_bus_ack) begin
          handler_pc_nxt = i_bus_rdata; // RULE_09
          state_nxt = CXS_ST_FETCH;
        end
      end
      CXS_ST_INTERRUPT_ACK_CYCLE: begin
        if (i_bus_ack) begin
          vector_nxt = i_bus_rdata[7:0]; // RULE_17
          bus_addr_nxt = frame_sp_r + `CXS_LONG_BYTES; // RULE_25
          bus_wdata_nxt = pc_stack_r;
          state_nxt = CXS_ST_PUSH_PC;
        end
      end
      CXS_ST_PUSH_PC: begin
        if (i_bus_ack) begin
          bus_addr_nxt = frame_sp_r; // RULE_25
          bus_wdata_nxt = frame_word; // RULE_13
          state_nxt = CXS_ST_PUSH_FV;
        end
      end
      CXS_ST_PUSH_FV: begin
        if (i_bus_ack) begin
          ssp_nxt = frame_sp_r; // RULE_25
          bus_addr_nxt = vbr_r + {22'h00_0000, vector_r, 2'b00}; // RULE_06
          state_nxt = CXS_ST_VEC_RD;
        end
      end
      CXS_ST_VEC_RD: begin
        if (i_bus_ack) begin
          handler_pc_nxt = i_bus_rdata; // RULE_06
          state_nxt = CXS_ST_FETCH;
        end
      end
      CXS_ST_FETCH: begin
        // Done once the first opcode fetch is issued; interrupts stay inhibited until the first handler instruction completes
        inhibit_nxt = 1'b1; // RULE_12
        state_nxt = CXS_ST_IDLE; // RULE_23
      end
      default: begin
        state_nxt = CXS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      // Reset runs the initial stack pointer and counter fetch from vector 0 and 1
      state_r <= CXS_ST_RST_SSP; // RULE_09
      status_r <= `CXS_SR_RESET;
      saved_sr_r <= 16'h0000;
      ssp_r <= 32'h0000_0000;
      vbr_r <= `CXS_VBR_RESET;
      vector_r <= `CXS_VEC_INIT_SSP;
      fs_r <= `CXS_FS_NONE;
      fmt_r <= 2'b00;
      pc_stack_r <= 32'h0000_0000;
      frame_sp_r <= 32'h0000_0000;
      irq_lvl_r <= 3'h0;
      bus_addr_r <= `CXS_VBR_RESET;
      bus_wdata_r <= 32'h0000_0000;
      handler_pc_r <= 32'h0000_0000;
      inhibit_r <= 1'b0;
      fetch_pend_r <= 1'b0;
      wr_err_pend_r <= 1'b0;
      wr_err_prot_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      status_r <= status_nxt;
      saved_sr_r <= saved_sr_nxt;
      ssp_r <= ssp_nxt;
      vbr_r <= vbr_nxt;
      vector_r <= vector_nxt;
      fs_r <= fs_nxt;
      fmt_r <= fmt_nxt;
      pc_stack_r <= pc_stack_nxt;
      frame_sp_r <= frame_sp_nxt;
      irq_lvl_r <= irq_lvl_nxt;
      bus_addr_r <= bus_addr_nxt;
      bus_wdata_r <= bus_wdata_nxt;
      handler_pc_r <= handler_pc_nxt;
      inhibit_r <= inhibit_nxt;
      fetch_pend_r <= fetch_pend_nxt;
      wr_err_pend_r <= wr_err_pend_nxt;
      wr_err_prot_r <= wr_err_prot_nxt;
    end
  end

  // Register read next value; unmapped offsets read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `CXS_REG_VBR: rdata_nxt = vbr_r;
        `CXS_REG_SSP: rdata_nxt = ssp_r;
        `CXS_REG_STATUS: rdata_nxt = {16'h0000, status_r};
        `CXS_REG_INFO: rdata_nxt = {state_r, vector_r, fs_r, irq_lvl_r, inhibit_r,
          fetch_pend_r, wr_err_pend_r, wr_err_prot_r, 5'h00};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_exc_taken = start;
  // Squash before writeback; earlier address updates of a read fault are kept
  assign o_abort = ev_ifetch | ev_rd; // RULE_19
  assign o_nop_stall = i_nop_active & i_writes_pending; // RULE_22
  assign o_busy = ~idle;
  assign o_bus_req = (state_r == CXS_ST_RST_SSP) | (state_r == CXS_ST_RST_PC) |
    (state_r == CXS_ST_INTERRUPT_ACK_CYCLE) | (state_r == CXS_ST_PUSH_PC) |
    (state_r == CXS_ST_PUSH_FV) | (state_r == CXS_ST_VEC_RD);
  assign o_bus_wr = (state_r == CXS_ST_PUSH_PC) | (state_r == CXS_ST_PUSH_FV);
  assign o_bus_interrupt_ack_cycle = (state_r == CXS_ST_INTERRUPT_ACK_CYCLE); // RULE_03
  assign o_bus_addr = bus_addr_r;
  assign o_bus_wdata = bus_wdata_r;
  assign o_fetch_req = (state_r == CXS_ST_FETCH); // RULE_23
  assign o_fetch_addr = handler_pc_r;
  assign o_status_word = status_r;
  assign o_ssp = ssp_r;

  chk_entry_super: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_01
    start |=> status_r[`CXS_SR_S] && !status_r[`CXS_SR_T] && saved_sr_r == $past(status_r))
    else $error("Entry did not save status and enter supervisor");

  chk_irq_mask: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_02
    (start && state_nxt == CXS_ST_INTERRUPT_ACK_CYCLE) |=>
      status_r[`CXS_SR_IMSK_HI:`CXS_SR_IMSK_LO] == $past(i_irq_level) &&
      !status_r[`CXS_SR_M])
    else $error("Interrupt entry mask or master flag wrong");

  chk_debug_keep: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_24
    (ev_exc && !ev_ifetch && !ev_rd && i_exc_kind == CXS_K_DEBUG) |=>
      state_r == CXS_ST_PUSH_PC && vector_r == `CXS_VEC_DEBUG &&
      status_r[`CXS_SR_M:`CXS_SR_IMSK_LO] == $past(status_r[`CXS_SR_M:`CXS_SR_IMSK_LO]))
    else $error("Debug entry altered mask or used wrong vector");

  chk_interrupt_ack_cycle_addr: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_03
    o_bus_interrupt_ack_cycle |-> o_bus_req && !o_bus_wr &&
      o_bus_addr == (`CXS_INTERRUPT_ACK_CYCLE_BASE | {27'h000_0000, irq_lvl_r, 2'b00}))
    else $error("Acknowledge cycle address does not carry the level");

  chk_frame_place: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_25
    (state_r == CXS_ST_PUSH_PC && i_bus_ack) |=>
      o_bus_addr == frame_sp_r && o_bus_addr[1:0] == 2'b00 &&
      $past(o_bus_addr) == frame_sp_r + `CXS_LONG_BYTES)
    else $error("Frame longwords misplaced or misaligned");

  chk_ssp_frame: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_14
    (state_r == CXS_ST_PUSH_FV && i_bus_ack) |=>
      ssp_r == {$past(ssp_r[31:2]), 2'b00} - `CXS_FRAME_BYTES)
    else $error("Stack pointer not lowered by the frame");

  chk_fmt_code: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_14
    state_r == CXS_ST_PUSH_FV |-> o_bus_wdata[31:28] == {`CXS_FMT_HI, fmt_r} &&
      o_bus_wdata[23:16] == vector_r)
    else $error("Format or vector field wrong in frame");

  chk_fs_zero: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_15
    (ev_exc && !ev_ifetch && !ev_rd && i_exc_kind != CXS_K_ADDRESS) |=> fs_r == `CXS_FS_NONE)
    else $error("Fault status filled for a non-access exception");

  chk_vec_index: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_06
    state_r == CXS_ST_VEC_RD |-> o_bus_addr == vbr_r + {22'h00_0000, vector_r, 2'b00})
    else $error("Vector read address wrong");

  chk_vbr_align: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_07
    vbr_r[19:0] == 20'h0_0000)
    else $error("Vector base not on a megabyte boundary");

  chk_irq_inhibit: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_12
    (o_fetch_req || (inhibit_r && !i_instr_done)) |=> inhibit_r && !ev_irq)
    else $error("Interrupt taken during first handler instruction");

  chk_fetch_exit: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_23
    (state_r == CXS_ST_VEC_RD && i_bus_ack) |=> o_fetch_req && o_fetch_addr == $past(i_bus_rdata)
      ##1 !o_busy)
    else $error("Handler fetch not issued or sequencer did not finish");

endmodule

// ### tb/cxs_mem_model.sv
// Purpose: Memory and interrupt controller model on the sequencer core bus
// Assumes: Request held until ack; i_wait adds wait cycles before the ack
// Notes: Data is inverted outside the ack cycle so a stale value never matches
`timescale 1ns/1ps
module cxs_mem_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_req,
  input wire logic i_interrupt_ack_cycle,
  input wire logic [31:0] i_addr,
  input wire logic [1:0] i_wait,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [31:0] val;
  always_comb begin
    o_ack = i_req && (cnt_r == i_wait);
    cnt_nxt = (i_req && !o_ack) ? cnt_r + 2'h1 : 2'h0;
    // Acknowledge returns vector 64 plus the level taken from the address
    val = i_interrupt_ack_cycle ? {24'h00_0000, 5'h08, i_addr[4:2]} : i_addr ^ 32'hA5A5_0000;
    o_rdata = o_ack ? val : ~val;
  end
  always_ff @(posedge i_clk) begin
    cnt_r <= i_reset ? 2'h0 : cnt_nxt;
  end
endmodule

// ### tb/cxs_exception_sequencer_tb_top.sv
// Purpose: Self-checking bench for the exception sequencer
// Assumes: 40 MHz clock, reset held two cycles, memory model on the core bus
// Notes: Frames are compared word by word; event strobes come from one trigger vector
`timescale 1ns/1ps
module cxs_exception_sequencer_tb_top
  import cxs_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] ra = 8'h00;
  logic [31:0] rwd = 32'h0000_0000;
  logic rwr = 1'b0;
  logic rrd = 1'b0;
  logic [8:0] trig = 9'h000;
  cxs_kind_t kind = CXS_K_ADDRESS;
  logic wprot = 1'b0;
  logic wpend = 1'b0;
  logic nopa = 1'b0;
  logic [2:0] lvl = 3'h0;
  logic [1:0] wt = 2'h0;
  logic [3:0] tn = 4'hF;
  logic [31:0] rdat, baddr, bwd, mrd, faddr, supervisor_stack_pointer, sp, vbr, qa;
  logic [15:0] sr;
  logic taken, abort, stall, breq, bwr, biack, ack, freq, busy;
  int error_cnt = 0;
  int n_checks = 0;
  logic [7:0] vt [10] = '{8'h03, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h2F};
  logic [9:0] nx = 10'h290;
  localparam logic [31:0] fpc = 32'h0000_1000;
  localparam logic [31:0] npc = 32'h0000_1006;
  always #12.5 clk = ~clk;
  cxs_exception_sequencer DUT (.i_clk(clk), .i_reset(reset), .i_reg_addr(ra), .i_reg_wdata(rwd),
    .i_reg_wr(rwr), .i_reg_rd(rrd), .o_reg_rdata(rdat), .i_exc_req(trig[0]), .i_exc_kind(kind),
    .i_trap_num(tn), .i_addr_err_fs(4'h4), .i_fault_pc(fpc), .i_next_pc(npc),
    .i_fetch_fault(trig[1]), .i_flow_change(trig[2]), .i_fault_word_used(trig[3]),
    .i_read_err(trig[4]), .i_write_err(trig[5]), .i_write_prot(wprot),
    .i_writes_pending(wpend & ~trig[8]), .i_nop_active(nopa), .i_instr_boundary(trig[6]),
    .i_instr_done(trig[7]), .i_irq_level(lvl), .o_exc_taken(taken), .o_abort(abort),
    .o_nop_stall(stall), .o_busy(busy), .o_bus_req(breq), .o_bus_wr(bwr), .o_bus_interrupt_ack_cycle(biack),
    .o_bus_addr(baddr), .o_bus_wdata(bwd), .i_bus_ack(ack), .i_bus_rdata(mrd),
    .o_fetch_req(freq), .o_fetch_addr(faddr), .o_status_word(sr), .o_ssp(supervisor_stack_pointer));
  cxs_mem_model MEM (.i_clk(clk), .i_reset(reset), .i_req(breq), .i_interrupt_ack_cycle(biack),
    .i_addr(baddr), .i_wait(wt), .o_ack(ack), .o_rdata(mrd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    @(negedge clk);
    chk(rdat, e);
  endtask
  // Strobes the given events and expects no exception to be taken
  task automatic quiet(input logic [8:0] m);
    int n;
    n = 0;
    @(posedge clk);
    trig <= m;
    repeat (4) begin
      @(negedge clk);
      if (taken !== 1'b0) n++;
      @(posedge clk);
      trig <= 9'h000;
    end
    chk(n, 0);
  endtask
  // Old status is always 0x9300: trace, master and mask 3 set, so every change shows
  task automatic run(input logic [8:0] m, input logic [7:0] v, input logic [31:0] pc,
      input logic [3:0] fs, input logic ab, input logic [2:0] q);
    logic [31:0] wa[$];
    logic [31:0] wd[$];
    logic [31:0] va;
    logic [31:0] fa;
    logic [31:0] al;
    logic tk;
    logic sab;
    logic fe;
    va = 32'h0000_0000;
    fa = va;
    tk = 1'b0;
    sab = 1'b0;
    fe = 1'b0;
    al = {sp[31:2], 2'h0};
    wr(8'h04, sp);
    wr(8'h08, 32'h0000_9300);
    @(posedge clk);
    trig <= m;
    for (int i = 0; i < 60 && !fe; i++) begin
      @(negedge clk);
      if (taken === 1'b1) begin
        tk = 1'b1;
        sab = abort;
      end
      if (breq && ack && bwr) begin
        wa.push_back(baddr);
        wd.push_back(bwd);
      end
      if (breq && ack && biack) qa = baddr;
      if (breq && ack && !bwr && !biack) va = baddr;
      if (freq === 1'b1) begin
        fe = 1'b1;
        fa = faddr;
      end
      @(posedge clk);
      trig <= 9'h000;
    end
    if (!fe) begin
      error_cnt++;
      give_verdict();
    end
    @(negedge clk);
    chk(tk, 1'b1);
    chk(sab, ab);
    chk(wa.size(), 2);
    chk(wa[0], al - 32'h0000_0004);
    chk(wd[0], pc);
    chk(wa[1], al - 32'h0000_0008);
    chk(wd[1], {2'h1, sp[1:0], fs, v, 16'h9300});
    chk(va, vbr + {22'h00_0000, v, 2'h0});
    chk(fa, (vbr + {22'h00_0000, v, 2'h0}) ^ 32'hA5A5_0000);
    chk(supervisor_stack_pointer, al - 32'h0000_0008);
    chk(busy, 1'b0);
    chk(sr, (q != 3'h0) ? (16'h2000 | {5'h00, q, 8'h00}) : 16'h3300);
  endtask
  initial begin
    sp = 32'h0000_2000;
    vbr = 32'h0000_0000;
    qa = vbr;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 40 && freq !== 1'b1; i++) @(negedge clk);
    if (freq !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
    chk(faddr, 32'hA5A5_0004);
    chk(supervisor_stack_pointer, 32'hA5A5_0000);
    chk(busy, 1'b1);
    wr(8'h00, 32'h1234_5678);
    rd(8'h00, 32'h1230_0000);
    rd(8'h10, 32'h0000_0000);
    rd(8'h0C, 32'h0100_0100);
    vbr = 32'h1230_0000;
    // Every fault kind, with wait states and stack pointer low bits rotating
    for (int k = 0; k < 10; k++) begin
      @(posedge clk);
      kind <= cxs_kind_t'(k);
      wt <= 2'(k % 3);
      sp = 32'h0000_2000 + k;
      run(9'h001, vt[k], nx[k] ? npc : fpc, (k == 0) ? 4'h4 : 4'h0, 1'b0, 3'h0);
    end
    @(posedge clk);
    tn <= 4'h0;
    run(9'h001, 8'h20, npc, 4'h0, 1'b0, 3'h0);
    quiet(9'h002);
    run(9'h008, 8'h02, fpc, 4'h4, 1'b1, 3'h0);
    run(9'h010, 8'h02, fpc, 4'hC, 1'b1, 3'h0);
    quiet(9'h020);
    run(9'h040, 8'h02, npc, 4'h8, 1'b0, 3'h0);
    @(posedge clk);
    wprot <= 1'b1;
    quiet(9'h020);
    run(9'h040, 8'h02, npc, 4'h9, 1'b0, 3'h0);
    @(posedge clk);
    wprot <= 1'b0;
    quiet(9'h002);
    quiet(9'h004);
    quiet(9'h008);
    @(posedge clk);
    nopa <= 1'b1;
    wpend <= 1'b1;
    @(negedge clk);
    chk(stall, 1'b1);
    quiet(9'h020);
    run(9'h100, 8'h02, fpc, 4'h8, 1'b0, 3'h0);
    @(posedge clk);
    nopa <= 1'b0;
    wpend <= 1'b0;
    lvl <= 3'h5;
    quiet(9'h080);
    run(9'h040, 8'h45, npc, 4'h0, 1'b0, 3'h5);
    chk(qa, 32'hFFFF_FFF4);
    @(posedge clk);
    lvl <= 3'h7;
    quiet(9'h040);
    quiet(9'h080);
    run(9'h040, 8'h47, npc, 4'h0, 1'b0, 3'h7);
    give_verdict();
  end
endmodule
